// ---- hdl/phy_ctrl_apply.v ----
// turns stored control fields into the levels the port-one transceiver and led pins see
// assumes every input is on clk_i; all outputs are flip-flops
`timescale 1ns/1ps
module phy_ctrl_apply (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // stored fields
    input wire led_off_i,
    input wire amdix_dis_i,
    input wire force_mdix_i,
    input wire an_en_i,
    input wire force_spd_i,
    input wire force_dpx_i,
    // transceiver and led sources
    input wire an_failed_i,
    input wire [3:0] led_in_i,
    // applied levels
    output reg [3:0] led_out_o,
    output reg force_mdix_o,
    output reg forced_link_o,
    output reg speed_100_o,
    output reg full_duplex_o
);

    // one register stage so every pin level comes from a flip-flop
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            led_out_o <= 4'hF;
            force_mdix_o <= 1'b0;
            forced_link_o <= 1'b0;
            speed_100_o <= 1'b0;
            full_duplex_o <= 1'b0;
        end else begin
            // blanked leds are driven high, i.e. dark
            led_out_o <= led_off_i ? 4'hF : led_in_i; // R1
            // forcing only counts once auto crossover is off
            force_mdix_o <= amdix_dis_i & force_mdix_i; // R5
            forced_link_o <= ~an_en_i; // R7
            speed_100_o <= force_spd_i; // R8
            // duplex is always the forced bit; an_failed_i is not used
            full_duplex_o <= force_dpx_i; // R9
        end
    end

endmodule

// ---- hdl/port1_phy_control.v ----
// port-one transceiver control register with a host view and a transceiver-side view
// assumes both register ports and all status inputs run on clk_i; no pin is read directly
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "port1_phy_control_defines.vh"

// How it works
// R1: led blanking bit 15 drives all four port-one leds high.
// R2: bit 14 disables the port transmitter.
// R3: writing one to bit 13 restarts auto-negotiation.
// R4: bit 10 disables automatic crossover; reset value keeps it enabled.
// R5: bit 9 forces crossover mode only while automatic crossover is disabled.
// R6: bit 8 loops port-two receive through port-one pmd/pma to port-two transmit.
// R7: bit 7 enables auto-negotiation, resets to one; else speed/duplex from bits 6,5.
// R8: bit 6 selects forced speed: one is 100, zero is 10.
// R9: bit 5 forces duplex when negotiation is off; an_failed_i does not affect it.
// R10: bit 4, reset one, advertises pause capability.
// R11: bits 3..0, reset one, advertise 100fd, 100hd, 10fd, 10hd.
// R12: bit 11 powers down the transceiver; bit 12 is plain storage.
// R13: one storage shared by the host view and the transceiver-side views.
module port1_phy_control #(
    parameter ADDR_W = `P1PC_ADDR_W,
    parameter DATA_W = `P1PC_DATA_W
) (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // host register port
    input wire [ADDR_W-1:0] addr_i,
    input wire [DATA_W-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [DATA_W-1:0] rdata_o,
    // transceiver-side register view
    input wire [ADDR_W-1:0] phy_addr_i,
    input wire [DATA_W-1:0] phy_wdata_i,
    input wire phy_wr_i,
    input wire phy_rd_i,
    output reg [DATA_W-1:0] phy_rdata_o,
    // transceiver status and led sources
    input wire an_failed_i,
    input wire [3:0] led_in_i,
    // led pins
    output wire port1_led_out_3_o,
    output wire port1_led_out_2_o,
    output wire port1_led_out_1_o,
    output wire port1_led_out_0_o,
    // transceiver controls
    output reg tx_disable_o,
    output reg restart_an_o,
    output reg power_down_o,
    output reg auto_mdix_en_o,
    output wire force_mdix_o,
    output reg far_end_loopback_o,
    output reg an_enable_o,
    output wire forced_link_o,
    output wire speed_100_o,
    output wire full_duplex_o,
    output reg [4:0] adv_o
);

    // the single copy of every control bit
    reg [15:0] ctrl;
    reg [15:0] next_ctrl;
    reg restart_req;
    wire [3:0] led_out;

    // host word to transceiver basic control layout
    function [15:0] to_phy_ctrl;
        input [15:0] c;
        begin
            to_phy_ctrl = 16'h0000;
            to_phy_ctrl[`PHYV_C_LED_OFF] = c[`P1PC_LED_OFF];
            to_phy_ctrl[`PHYV_C_TX_DIS] = c[`P1PC_TX_DIS];
            to_phy_ctrl[`PHYV_C_RSVD] = c[`P1PC_RSVD];
            to_phy_ctrl[`PHYV_C_AMDIX_DIS] = c[`P1PC_AMDIX_DIS];
            to_phy_ctrl[`PHYV_C_FORCE_MDIX] = c[`P1PC_FORCE_MDIX];
            to_phy_ctrl[`PHYV_C_FORCE_DPX] = c[`P1PC_FORCE_DPX];
            to_phy_ctrl[`PHYV_C_RESTART_AN] = c[`P1PC_RESTART_AN];
            to_phy_ctrl[`PHYV_C_POWER_DOWN] = c[`P1PC_POWER_DOWN];
            to_phy_ctrl[`PHYV_C_AN_EN] = c[`P1PC_AN_EN];
            to_phy_ctrl[`PHYV_C_FORCE_SPD] = c[`P1PC_FORCE_SPD];
            to_phy_ctrl[`PHYV_C_FAR_LOOP] = c[`P1PC_FAR_LOOP];
        end
    endfunction

    // host word to transceiver advertisement layout
    function [15:0] to_phy_adv;
        input [15:0] c;
        begin
            to_phy_adv = 16'h0000;
            to_phy_adv[`PHYV_A_PAUSE] = c[`P1PC_ADV_PAUSE];
            to_phy_adv[`PHYV_A_100FD] = c[`P1PC_ADV_100FD];
            to_phy_adv[`PHYV_A_100HD] = c[`P1PC_ADV_100HD];
            to_phy_adv[`PHYV_A_10FD] = c[`P1PC_ADV_10FD];
            to_phy_adv[`PHYV_A_10HD] = c[`P1PC_ADV_10HD];
        end
    endfunction

    // merge a transceiver basic control write into the host word
    function [15:0] from_phy_ctrl;
        input [15:0] c;
        input [15:0] w;
        begin
            from_phy_ctrl = c;
            from_phy_ctrl[`P1PC_LED_OFF] = w[`PHYV_C_LED_OFF];
            from_phy_ctrl[`P1PC_TX_DIS] = w[`PHYV_C_TX_DIS];
            from_phy_ctrl[`P1PC_RSVD] = w[`PHYV_C_RSVD];
            from_phy_ctrl[`P1PC_AMDIX_DIS] = w[`PHYV_C_AMDIX_DIS];
            from_phy_ctrl[`P1PC_FORCE_MDIX] = w[`PHYV_C_FORCE_MDIX];
            from_phy_ctrl[`P1PC_FORCE_DPX] = w[`PHYV_C_FORCE_DPX];
            from_phy_ctrl[`P1PC_RESTART_AN] = w[`PHYV_C_RESTART_AN];
            from_phy_ctrl[`P1PC_POWER_DOWN] = w[`PHYV_C_POWER_DOWN];
            from_phy_ctrl[`P1PC_AN_EN] = w[`PHYV_C_AN_EN];
            from_phy_ctrl[`P1PC_FORCE_SPD] = w[`PHYV_C_FORCE_SPD];
            from_phy_ctrl[`P1PC_FAR_LOOP] = w[`PHYV_C_FAR_LOOP];
        end
    endfunction

    // merge a transceiver advertisement write into the host word
    function [15:0] from_phy_adv;
        input [15:0] c;
        input [15:0] w;
        begin
            from_phy_adv = c;
            from_phy_adv[`P1PC_ADV_PAUSE] = w[`PHYV_A_PAUSE];
            from_phy_adv[`P1PC_ADV_100FD] = w[`PHYV_A_100FD];
            from_phy_adv[`P1PC_ADV_100HD] = w[`PHYV_A_100HD];
            from_phy_adv[`P1PC_ADV_10FD] = w[`PHYV_A_10FD];
            from_phy_adv[`P1PC_ADV_10HD] = w[`PHYV_A_10HD];
        end
    endfunction

    wire host_wr = wr_i && (addr_i == `P1PC_OFFSET);
    wire phy_ctrl_wr = phy_wr_i && (phy_addr_i == `PHYV_CTRL_OFFSET);
    wire phy_adv_wr = phy_wr_i && (phy_addr_i == `PHYV_ADV_OFFSET);

    // transceiver view is applied first so a same-cycle host write wins
    always @* begin
        next_ctrl = ctrl;
        restart_req = 1'b0;
        if (phy_ctrl_wr) begin
            next_ctrl = from_phy_ctrl(next_ctrl, phy_wdata_i); // R13
            restart_req = phy_wdata_i[`PHYV_C_RESTART_AN];
        end
        if (phy_adv_wr) begin
            next_ctrl = from_phy_adv(next_ctrl, phy_wdata_i); // R13
        end
        if (host_wr) begin
            next_ctrl = wdata_i[15:0]; // R12
            restart_req = restart_req | wdata_i[`P1PC_RESTART_AN];
        end
    end

    // storage; unmapped writes leave it alone
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl <= `P1PC_RESET; // R7 R10 R11
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads give zero
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
            phy_rdata_o <= 16'h0000;
        end else begin
            rdata_o <= (rd_i && addr_i == `P1PC_OFFSET) ? ctrl : 16'h0000;
            if (phy_rd_i && phy_addr_i == `PHYV_CTRL_OFFSET) begin
                phy_rdata_o <= to_phy_ctrl(ctrl); // R13
            end else if (phy_rd_i && phy_addr_i == `PHYV_ADV_OFFSET) begin
                phy_rdata_o <= to_phy_adv(ctrl); // R13
            end else begin
                phy_rdata_o <= 16'h0000;
            end
        end
    end

    // direct control levels, registered from the stored bits; the restart pulse is registered from the write
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            tx_disable_o <= 1'b0;
            restart_an_o <= 1'b0;
            power_down_o <= 1'b0;
            auto_mdix_en_o <= 1'b1;
            far_end_loopback_o <= 1'b0;
            an_enable_o <= 1'b1;
            adv_o <= 5'h1F;
        end else begin
            tx_disable_o <= ctrl[`P1PC_TX_DIS]; // R2
            // a pulse per write of one; a stored one alone does not repeat it
            restart_an_o <= restart_req; // R3
            power_down_o <= ctrl[`P1PC_POWER_DOWN]; // R12
            auto_mdix_en_o <= ~ctrl[`P1PC_AMDIX_DIS]; // R4
            far_end_loopback_o <= ctrl[`P1PC_FAR_LOOP]; // R6
            an_enable_o <= ctrl[`P1PC_AN_EN]; // R7
            adv_o <= ctrl[4:0]; // R10 R11
        end
    end

    // forced-mode and led resolution
    phy_ctrl_apply u_apply (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .led_off_i(ctrl[`P1PC_LED_OFF]),
        .amdix_dis_i(ctrl[`P1PC_AMDIX_DIS]),
        .force_mdix_i(ctrl[`P1PC_FORCE_MDIX]),
        .an_en_i(ctrl[`P1PC_AN_EN]),
        .force_spd_i(ctrl[`P1PC_FORCE_SPD]),
        .force_dpx_i(ctrl[`P1PC_FORCE_DPX]),
        .an_failed_i(an_failed_i),
        .led_in_i(led_in_i),
        .led_out_o(led_out),
        .force_mdix_o(force_mdix_o),
        .forced_link_o(forced_link_o),
        .speed_100_o(speed_100_o),
        .full_duplex_o(full_duplex_o)
    );

    assign port1_led_out_3_o = led_out[3]; // R1
    assign port1_led_out_2_o = led_out[2];
    assign port1_led_out_1_o = led_out[1];
    assign port1_led_out_0_o = led_out[0];

endmodule

// ---- hdl/port1_phy_control_defines.vh ----
// constants for the port-one transceiver control register and its transceiver-side view
// assumes plain inclusion by bare name from the design files
`ifndef PORT1_PHY_CONTROL_DEFINES_VH
`define PORT1_PHY_CONTROL_DEFINES_VH

// host register bus
`define P1PC_ADDR_W 8
`define P1PC_DATA_W 16
`define P1PC_OFFSET 8'h02
`define P1PC_RESET 16'h009F

// host view field positions
`define P1PC_LED_OFF 15
`define P1PC_TX_DIS 14
`define P1PC_RESTART_AN 13
`define P1PC_RSVD 12
`define P1PC_POWER_DOWN 11
`define P1PC_AMDIX_DIS 10
`define P1PC_FORCE_MDIX 9
`define P1PC_FAR_LOOP 8
`define P1PC_AN_EN 7
`define P1PC_FORCE_SPD 6
`define P1PC_FORCE_DPX 5
`define P1PC_ADV_PAUSE 4
`define P1PC_ADV_100FD 3
`define P1PC_ADV_100HD 2
`define P1PC_ADV_10FD 1
`define P1PC_ADV_10HD 0

// transceiver-side view offsets
`define PHYV_CTRL_OFFSET 8'h00
`define PHYV_ADV_OFFSET 8'h08

// transceiver-side basic control field positions
`define PHYV_C_LED_OFF 0
`define PHYV_C_TX_DIS 1
`define PHYV_C_RSVD 2
`define PHYV_C_AMDIX_DIS 3
`define PHYV_C_FORCE_MDIX 4
`define PHYV_C_FORCE_DPX 8
`define PHYV_C_RESTART_AN 9
`define PHYV_C_POWER_DOWN 11
`define PHYV_C_AN_EN 12
`define PHYV_C_FORCE_SPD 13
`define PHYV_C_FAR_LOOP 14

// transceiver-side advertisement field positions
`define PHYV_A_PAUSE 10
`define PHYV_A_100FD 8
`define PHYV_A_100HD 7
`define PHYV_A_10FD 6
`define PHYV_A_10HD 5

`endif

// ---- sim/port1_phy_control_asserts.sv ----
// checker for the port-one transceiver control register
// assumes binding to port1_phy_control; controls follow a host write two edges later, the restart pulse one edge later
`timescale 1ns/1ps
`include "port1_phy_control_defines.vh"
module port1_phy_control_asserts #(
    parameter ADDR_W = 8,
    parameter DATA_W = 16
) (
    // clock, reset and host port
    input logic clk_i,
    input logic rst_b_i,
    input logic [ADDR_W-1:0] addr_i,
    input logic [DATA_W-1:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    input logic [DATA_W-1:0] rdata_o,
    // leds and transceiver controls
    input logic port1_led_out_3_o,
    input logic port1_led_out_2_o,
    input logic port1_led_out_1_o,
    input logic port1_led_out_0_o,
    input logic tx_disable_o,
    input logic restart_an_o,
    input logic power_down_o,
    input logic auto_mdix_en_o,
    input logic force_mdix_o,
    input logic far_end_loopback_o,
    input logic an_enable_o,
    input logic forced_link_o,
    input logic speed_100_o,
    input logic full_duplex_o,
    input logic [4:0] adv_o
);
    // write data two edges back, when its effect reaches the pins
    logic [DATA_W-1:0] w1;
    logic [DATA_W-1:0] w2;
    wire wr_hit = wr_i && addr_i == `P1PC_OFFSET;
    always_ff @(posedge clk_i) begin
        w1 <= wdata_i;
        w2 <= w1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_led_blank: assert property (wr_hit && wdata_i[15] |-> ##2 {port1_led_out_3_o, port1_led_out_2_o,
        port1_led_out_1_o, port1_led_out_0_o} == 4'hf) else $error("leds not blanked");
    a_tx_disable: assert property (wr_hit |-> ##2 tx_disable_o == w2[14])
        else $error("transmit disable wrong");
    a_restart_pulse: assert property (wr_hit && wdata_i[13] |-> ##1 restart_an_o)
        else $error("no restart pulse");
    a_auto_mdix: assert property (wr_hit |-> ##2 auto_mdix_en_o != w2[10])
        else $error("auto crossover wrong");
    a_force_mdix: assert property (wr_hit |-> ##2 force_mdix_o == (w2[10] && w2[9]))
        else $error("forced crossover wrong");
    a_far_loop: assert property (wr_hit |-> ##2 far_end_loopback_o == w2[8])
        else $error("loopback wrong");
    a_an_select: assert property (wr_hit |-> ##2 an_enable_o == w2[7] && forced_link_o != w2[7])
        else $error("negotiation select wrong");
    a_speed_duplex: assert property (wr_hit |-> ##2 speed_100_o == w2[6] && full_duplex_o == w2[5])
        else $error("forced speed or duplex wrong");
    a_adv_bits: assert property (wr_hit |-> ##2 adv_o == w2[4:0])
        else $error("advertisement wrong");
    a_power_down: assert property (wr_hit |-> ##2 power_down_o == w2[11])
        else $error("power down wrong");
    a_read_back: assert property (wr_hit ##1 (rd_i && addr_i == `P1PC_OFFSET) |=> rdata_o == w2)
        else $error("read back wrong");
    // main scenarios
    cover property (wr_hit && wdata_i[15]);
    cover property (restart_an_o);
    cover property (wr_hit && !wdata_i[7]);
endmodule
bind port1_phy_control port1_phy_control_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) port1_phy_control_asserts_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .port1_led_out_3_o(port1_led_out_3_o), .port1_led_out_2_o(port1_led_out_2_o),
    .port1_led_out_1_o(port1_led_out_1_o), .port1_led_out_0_o(port1_led_out_0_o), .tx_disable_o(tx_disable_o),
    .restart_an_o(restart_an_o), .power_down_o(power_down_o), .auto_mdix_en_o(auto_mdix_en_o),
    .force_mdix_o(force_mdix_o), .far_end_loopback_o(far_end_loopback_o), .an_enable_o(an_enable_o),
    .forced_link_o(forced_link_o), .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o), .adv_o(adv_o));

// ---- sim/port1_phy_control_tb_top.sv ----
// self-checking bench for the port-one transceiver control register
// assumes the checker is bound in; both register views driven from here
`timescale 1ns/1ps
module port1_phy_control_tb_top;
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic [7:0] addr_i = 0, phy_addr_i = 0;
    logic [15:0] wdata_i = 0, phy_wdata_i = 0;
    logic wr_i = 0, rd_i = 0, phy_wr_i = 0, phy_rd_i = 0, an_failed_i = 0, seen;
    logic [3:0] led_in_i = 4'h5;
    wire [15:0] rdata_o, phy_rdata_o;
    wire [3:0] leds;
    wire tx, rs, pd, am, fm, lp, an, fl, sp, fd;
    wire [4:0] adv;
    int bad_count = 0, compares = 0, cyc = 0;
    logic [15:0] vals [14] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0600,
        16'h0200, 16'h0100, 16'h0060, 16'h0040, 16'h0000, 16'hffff, 16'h0015};

    port1_phy_control port1_phy_control_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .phy_addr_i(phy_addr_i),
        .phy_wdata_i(phy_wdata_i), .phy_wr_i(phy_wr_i), .phy_rd_i(phy_rd_i), .phy_rdata_o(phy_rdata_o),
        .an_failed_i(an_failed_i), .led_in_i(led_in_i), .port1_led_out_3_o(leds[3]),
        .port1_led_out_2_o(leds[2]), .port1_led_out_1_o(leds[1]), .port1_led_out_0_o(leds[0]),
        .tx_disable_o(tx), .restart_an_o(rs), .power_down_o(pd), .auto_mdix_en_o(am), .force_mdix_o(fm),
        .far_end_loopback_o(lp), .an_enable_o(an), .forced_link_o(fl), .speed_100_o(sp),
        .full_duplex_o(fd), .adv_o(adv));

    initial forever #5 clk_i = ~clk_i;

    // hang guard, far above the ~100 cycles the sequence needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // both address buses carry a; the strobe picks the view
    task automatic wr(input bit phy, input logic [7:0] a, input logic [15:0] d);
        wr_i <= !phy;
        phy_wr_i <= phy;
        addr_i <= a;
        phy_addr_i <= a;
        wdata_i <= d;
        phy_wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 0;
        phy_wr_i <= 0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input bit phy, input logic [7:0] a, input logic [15:0] exp);
        rd_i <= !phy;
        phy_rd_i <= phy;
        addr_i <= a;
        phy_addr_i <= a;
        @(posedge clk_i);
        rd_i <= 0;
        phy_rd_i <= 0;
        #1 cmp("read data", {16'h0, exp}, {16'h0, phy ? phy_rdata_o : rdata_o});
        @(posedge clk_i);
    endtask

    // expected pin levels worked out from the stored word
    task automatic chk_out(input logic [15:0] c);
        cmp("controls", {14'h0, c[15] ? 4'hf : led_in_i, c[14], c[11], !c[10], c[10] & c[9], c[8], c[7],
            !c[7], c[6], c[5], c[4:0]}, {14'h0, leds, tx, pd, am, fm, lp, an, fl, sp, fd, adv});
    endtask

    task automatic final_report();
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1;
        rd(0, 8'h02, 16'h009f);
        chk_out(16'h009f);
        rd(1, 8'h00, 16'h1000);
        rd(1, 8'h08, 16'h05e0);
        foreach (vals[i]) begin
            an_failed_i <= vals[i][0];
            // a fresh led pattern per step so blanking cannot hide behind an all-ones input
            led_in_i <= 4'(i);
            wr(0, 8'h02, vals[i]);
            #1 seen = rs;
            @(posedge clk_i);
            #1 seen = seen | rs;
            chk_out(vals[i]);
            cmp("restart pulse", {31'h0, vals[i][13]}, {31'h0, seen});
            @(posedge clk_i);
            rd(0, 8'h02, vals[i]);
        end
        // the other view shares storage; unmapped places stay inert
        wr(1, 8'h00, 16'h0201);
        #1 cmp("phy view restart", 32'h1, {31'h0, rs});
        @(posedge clk_i);
        rd(0, 8'h02, 16'ha015);
        wr(1, 8'h08, 16'h0400);
        rd(0, 8'h02, 16'ha010);
        wr(0, 8'h02, 16'h0003);
        rd(0, 8'h02, 16'h0003);
        rd(1, 8'h08, 16'h0060);
        rd(1, 8'h00, 16'h0000);
        wr(0, 8'h04, 16'hffff);
        rd(0, 8'h04, 16'h0000);
        rd(0, 8'h02, 16'h0003);
        final_report();
    end
endmodule
